// ### design/bfr_pkg.sv
// Constants shared by the bridge fault response block and its
// host reset hold timer.
// Assumes a single 100 MHz system clock for every count below.
package bfr_pkg;

  // Bridge size, demand width and APB address width defaults
  localparam int NUM_SW = 6;
  localparam int DEMAND_W = 8;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SOF = 1;
  localparam int CTRL_ARC = 2;
  localparam int CTRL_DSR = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Event / live condition bit positions, shared by status and irq
  localparam int NUM_EV = 8;
  localparam int EV_MAIN_UV = 0;
  localparam int EV_LOGIC_UV = 1;
  localparam int EV_GDREG_UV = 2;
  localparam int EV_BOOT_UV = 3;
  localparam int EV_VDS_OV = 4;
  localparam int EV_TEMP_WARN = 5;
  localparam int EV_OVERTEMP = 6;
  localparam int EV_SYNC_LOSS = 7;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // Latched fault state bit positions
  localparam int NUM_LT = 4;
  localparam int LT_MAIN_UV = 0;
  localparam int LT_SYNC = 1;
  localparam int LT_SWITCH = 2;
  localparam int LT_RESET = 3;

  // Host reset hold time after the condition goes away
  localparam int HOLD_TIME_MS = 10;
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_FREQ_KHZ;

  // Host reset sequencer, Gray coded along free -> held -> wait
  typedef enum logic [1:0] {
    HR_FREE = 2'b00,
    HR_HELD = 2'b01,
    HR_WAIT = 2'b11
  } bfr_hr_state_t;

endpackage : bfr_pkg

// ### design/bfr_hold_timer.sv
// Host reset output sequencer: holds the reset low while a request is
// present and for a fixed count after it goes away.
// Assumes the request is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module bfr_hold_timer #(
  parameter int unsigned HOLD_CYCLES = bfr_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Reset request and resulting output
  input wire logic hold_req,
  output logic host_reset_out_n
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    bfr_pkg::bfr_hr_state_t state;
    logic [CW-1:0] cnt;
    logic rst_n;
  } bfr_hr_regs_t;

  bfr_hr_regs_t s;
  bfr_hr_regs_t next_s;

  always_comb begin
    next_s = s;
    case (s.state)
      bfr_pkg::HR_FREE: begin
        if (hold_req) begin
          next_s.state = bfr_pkg::HR_HELD;
          next_s.rst_n = 1'b0;
        end
      end
      bfr_pkg::HR_HELD: begin
        next_s.rst_n = 1'b0;
        if (!hold_req) begin
          next_s.state = bfr_pkg::HR_WAIT;
          next_s.cnt = '0;
        end
      end
      bfr_pkg::HR_WAIT: begin
        if (hold_req) begin
          next_s.state = bfr_pkg::HR_HELD;
        end else if (s.cnt == CW'(HOLD_CYCLES - 1)) begin
          next_s.state = bfr_pkg::HR_FREE;
          next_s.rst_n = 1'b1;
        end else begin
          next_s.cnt = s.cnt + CW'(1);
        end
      end
      default: begin
        next_s.state = bfr_pkg::HR_HELD;
        next_s.rst_n = 1'b0;
      end
    endcase
  end

  // Host stays in reset for the hold time after our own reset too
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{state: bfr_pkg::HR_WAIT, cnt: '0, rst_n: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign host_reset_out_n = s.rst_n;

endmodule : bfr_hold_timer
`default_nettype wire

// ### design/bfr_top.sv
// Bridge fault response logic with an APB register slave.
// Assumes fault inputs, gate requests and demand are synchronous
// levels on SYS_CLK; the host drives APB with zero-wait expectations.
`timescale 1ns/10ps
`default_nettype none
module bfr_top #(
  parameter int NUM_SW = bfr_pkg::NUM_SW,
  parameter int DEMAND_W = bfr_pkg::DEMAND_W,
  parameter int unsigned HOLD_CYCLES = bfr_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [bfr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Fault conditions from the detectors
  input wire logic FLT_MAIN_UV,
  input wire logic FLT_LOGIC_UV,
  input wire logic FLT_GDREG_UV,
  input wire logic [NUM_SW-1:0] FLT_BOOT_UV,
  input wire logic [NUM_SW-1:0] FLT_VDS_OV,
  input wire logic FLT_TEMP_WARN,
  input wire logic FLT_OVERTEMP,
  input wire logic FLT_SYNC_LOSS,
  // Commutation requests and operating demand
  input wire logic [NUM_SW-1:0] GATE_REQ,
  input wire logic [DEMAND_W-1:0] DEMAND,
  // Bridge gate drives and motor control
  output logic [NUM_SW-1:0] GATE_OUT,
  output logic MOTOR_RESTART,
  // Host supervision
  output logic HOST_RESET_OUT_N,
  output logic IRQ
);

  typedef struct packed {
    logic [bfr_pkg::CTRL_W-1:0] ctrl;
    logic [bfr_pkg::NUM_EV-1:0] irq_mask;
    logic [bfr_pkg::NUM_EV-1:0] irq_stat;
    logic [bfr_pkg::NUM_EV-1:0] cond_q;
    logic [bfr_pkg::NUM_LT-1:0] latch;
    logic [NUM_SW-1:0] sw_rec;
    logic inhibit;
    logic rst_inhibit;
    logic run_q;
    logic dem_zero_q;
    logic host_rst_q;
    logic [NUM_SW-1:0] req_q;
    logic [NUM_SW-1:0] block;
    logic [NUM_SW-1:0] gate;
    logic restart;
    logic irq;
    logic [31:0] prdata;
  } bfr_top_regs_t;

  bfr_top_regs_t s;
  bfr_top_regs_t next_s;

  logic [bfr_pkg::NUM_EV-1:0] live;
  logic [bfr_pkg::NUM_EV-1:0] rise;
  logic [bfr_pkg::NUM_EV-1:0] w1c;
  logic [NUM_SW-1:0] sw_cond;
  logic [NUM_SW-1:0] req_rise;
  logic [NUM_SW-1:0] next_block;
  logic [7:0] addr;
  logic stop_on_fault_enable;
  logic arc;
  logic dsr;
  logic run;
  logic dem_nz;
  logic setup_rd;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic permitted_read;
  logic clear_evt;
  logic reenable;
  logic hr_release;
  logic live_full;
  logic drive_ok;
  logic set_main;
  logic set_sync;
  logic set_sw;
  logic set_rst;
  logic host_rst_n;
  logic [31:0] status_word;
  logic [31:0] diag_word;
  logic [31:0] rd_mux;

  // Live conditions in event bit order
  assign live = {FLT_SYNC_LOSS, FLT_OVERTEMP, FLT_TEMP_WARN,
                 |FLT_VDS_OV, |FLT_BOOT_UV, FLT_GDREG_UV,
                 FLT_LOGIC_UV, FLT_MAIN_UV};
  assign rise = live & ~s.cond_q;
  assign sw_cond = FLT_BOOT_UV | FLT_VDS_OV;
  assign req_rise = GATE_REQ & ~s.req_q;

  assign stop_on_fault_enable = s.ctrl[bfr_pkg::CTRL_SOF];
  assign arc = s.ctrl[bfr_pkg::CTRL_ARC];
  assign dsr = s.ctrl[bfr_pkg::CTRL_DSR];
  assign run = s.ctrl[bfr_pkg::CTRL_RUN];
  assign dem_nz = |DEMAND;

  // APB decode; registers sit on aligned words
  assign addr = {PADDR[7:2], 2'b00};
  assign mapped = (addr == bfr_pkg::OFS_CTRL) ||
                  (addr == bfr_pkg::OFS_STATUS) ||
                  (addr == bfr_pkg::OFS_DIAG) ||
                  (addr == bfr_pkg::OFS_IRQ_STAT) ||
                  (addr == bfr_pkg::OFS_IRQ_MASK);
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  assign w1c = (wr_acc && addr == bfr_pkg::OFS_IRQ_STAT) ?
               PWDATA[bfr_pkg::NUM_EV-1:0] : '0;

  assign permitted_read = rd_acc && !dsr &&
                          ((addr == bfr_pkg::OFS_STATUS) ||
                           (addr == bfr_pkg::OFS_DIAG));
  assign clear_evt = !dem_nz || !run || permitted_read;
  assign reenable = (s.dem_zero_q && dem_nz) || (!s.run_q && run);
  assign hr_release = host_rst_n && !s.host_rst_q;

  assign set_main = rise[bfr_pkg::EV_MAIN_UV] && !arc;
  assign set_sync = rise[bfr_pkg::EV_SYNC_LOSS] && !arc;
  assign set_sw = stop_on_fault_enable && (rise[bfr_pkg::EV_BOOT_UV] ||
                          rise[bfr_pkg::EV_VDS_OV]);
  assign set_rst = rise[bfr_pkg::EV_LOGIC_UV] ||
                   (stop_on_fault_enable && rise[bfr_pkg::EV_OVERTEMP]);

  assign live_full = live[bfr_pkg::EV_GDREG_UV] ||
                     live[bfr_pkg::EV_LOGIC_UV] ||
                     live[bfr_pkg::EV_SYNC_LOSS] ||
                     (stop_on_fault_enable && (live[bfr_pkg::EV_MAIN_UV] ||
                              live[bfr_pkg::EV_BOOT_UV] ||
                              live[bfr_pkg::EV_VDS_OV] ||
                              live[bfr_pkg::EV_OVERTEMP]));
  assign drive_ok = run && dem_nz && !s.inhibit && !s.rst_inhibit &&
                    !live_full && host_rst_n;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SW; gi++) begin : g_sw
      assign next_block[gi] = (!stop_on_fault_enable && sw_cond[gi]) ||
                              (s.block[gi] && !req_rise[gi]);
    end
  endgenerate

  assign status_word = {10'h000, s.block, drive_ok, !host_rst_n,
                        s.rst_inhibit, s.inhibit, s.latch, live};
  assign diag_word = {18'h00000, FLT_VDS_OV, 2'h0, FLT_BOOT_UV};

  always_comb begin
    case (addr)
      bfr_pkg::OFS_CTRL: rd_mux = {28'h0000000, s.ctrl};
      bfr_pkg::OFS_STATUS: rd_mux = status_word;
      bfr_pkg::OFS_DIAG: rd_mux = diag_word;
      bfr_pkg::OFS_IRQ_STAT: rd_mux = {24'h000000, s.irq_stat};
      bfr_pkg::OFS_IRQ_MASK: rd_mux = {24'h000000, s.irq_mask};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.cond_q = live;
    next_s.run_q = run;
    next_s.dem_zero_q = !dem_nz;
    next_s.host_rst_q = host_rst_n;
    next_s.req_q = GATE_REQ;

    // Register writes and read data capture
    if (wr_acc && addr == bfr_pkg::OFS_CTRL) begin
      next_s.ctrl = PWDATA[bfr_pkg::CTRL_W-1:0];
    end
    if (wr_acc && addr == bfr_pkg::OFS_IRQ_MASK) begin
      next_s.irq_mask = PWDATA[bfr_pkg::NUM_EV-1:0];
    end
    if (setup_rd) begin
      next_s.prdata = rd_mux;
    end

    // New events win over a write-one clear
    next_s.irq_stat = rise | (s.irq_stat & ~w1c);
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

    next_s.latch[bfr_pkg::LT_MAIN_UV] = set_main ||
      (s.latch[bfr_pkg::LT_MAIN_UV] && !clear_evt);
    next_s.latch[bfr_pkg::LT_SYNC] = set_sync ||
      (s.latch[bfr_pkg::LT_SYNC] && !clear_evt);
    next_s.latch[bfr_pkg::LT_SWITCH] = set_sw ||
      (s.latch[bfr_pkg::LT_SWITCH] && !clear_evt);
    next_s.latch[bfr_pkg::LT_RESET] = set_rst ||
      (s.latch[bfr_pkg::LT_RESET] && !hr_release);
    next_s.sw_rec = (stop_on_fault_enable ? sw_cond : '0) |
      (s.sw_rec & ~(clear_evt ? {NUM_SW{1'b1}} : '0));

    next_s.inhibit = set_sync || (stop_on_fault_enable && set_main) || set_sw ||
                     (s.inhibit && !reenable);
    next_s.rst_inhibit = set_rst ||
      (s.rst_inhibit && !(reenable || permitted_read));

    next_s.block = next_block;
    next_s.gate = drive_ok ? (GATE_REQ & ~s.block & ~sw_cond) : '0;

    next_s.restart = arc && s.cond_q[bfr_pkg::EV_SYNC_LOSS] &&
                     !live[bfr_pkg::EV_SYNC_LOSS];
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '0;
      s.ctrl <= bfr_pkg::CTRL_RESET;
      s.irq_mask <= bfr_pkg::IRQ_MASK_RESET;
      s.dem_zero_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  bfr_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .hold_req(FLT_LOGIC_UV || (stop_on_fault_enable && FLT_OVERTEMP)),
    .host_reset_out_n(host_rst_n)
  );

  assign PRDATA = s.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign GATE_OUT = s.gate;
  assign MOTOR_RESTART = s.restart;
  assign HOST_RESET_OUT_N = host_rst_n;
  assign IRQ = s.irq;

endmodule : bfr_top
`default_nettype wire

// ### dv/bfr_top_assertions.sv
// Port checker for bfr_top.
// Assumes a host reset hold longer than eight cycles.
`timescale 1ns/10ps
`default_nettype none
module bfr_top_assertions #(
  parameter int NUM_SW = bfr_pkg::NUM_SW,
  parameter int DEMAND_W = bfr_pkg::DEMAND_W
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [bfr_pkg::ADDR_W-1:0] PADDR,
  input wire logic PSLVERR,
  // Faults and requests
  input wire logic FLT_LOGIC_UV,
  input wire logic [NUM_SW-1:0] FLT_BOOT_UV,
  input wire logic [NUM_SW-1:0] FLT_VDS_OV,
  input wire logic FLT_SYNC_LOSS,
  input wire logic [NUM_SW-1:0] GATE_REQ,
  input wire logic [DEMAND_W-1:0] DEMAND,
  // Outputs
  input wire logic [NUM_SW-1:0] GATE_OUT,
  input wire logic MOTOR_RESTART,
  input wire logic HOST_RESET_OUT_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  a_gate_subset: assert property (
    1'b1 |=> (GATE_OUT & ~$past(GATE_REQ)) == '0) else $error("gate unasked");
  a_boot_off: assert property (
    FLT_BOOT_UV != '0 |=> (GATE_OUT & $past(FLT_BOOT_UV)) == '0)
    else $error("gate on in boot fault");
  a_vds_off: assert property (
    FLT_VDS_OV != '0 |=> (GATE_OUT & $past(FLT_VDS_OV)) == '0)
    else $error("gate on in vds fault");
  a_demand_zero: assert property (DEMAND == '0 |=> GATE_OUT == '0)
    else $error("gate on at zero demand");
  a_sync_off: assert property (FLT_SYNC_LOSS |=> GATE_OUT == '0)
    else $error("gate on in sync loss");
  a_logic_off: assert property (
    FLT_LOGIC_UV |=> GATE_OUT == '0 && !HOST_RESET_OUT_N)
    else $error("logic fault not handled");
  a_hold_time: assert property (
    $rose(HOST_RESET_OUT_N) |-> $past(FLT_LOGIC_UV, 8) == 1'b0)
    else $error("host reset released early");
  a_restart_pulse: assert property (MOTOR_RESTART |=> !MOTOR_RESTART)
    else $error("restart pulse too long");
  a_bad_addr: assert property (
    PSEL && PENABLE |-> PSLVERR == (PADDR > 8'h13)) else $error("bad error");
endmodule : bfr_top_assertions
bind bfr_top bfr_top_assertions #(.NUM_SW(NUM_SW),
  .DEMAND_W(DEMAND_W)) u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR),
  .FLT_LOGIC_UV(FLT_LOGIC_UV), .FLT_BOOT_UV(FLT_BOOT_UV),
  .FLT_VDS_OV(FLT_VDS_OV), .FLT_SYNC_LOSS(FLT_SYNC_LOSS),
  .GATE_REQ(GATE_REQ), .DEMAND(DEMAND), .GATE_OUT(GATE_OUT),
  .MOTOR_RESTART(MOTOR_RESTART), .HOST_RESET_OUT_N(HOST_RESET_OUT_N));
`default_nettype wire

// ### dv/bfr_host_model.sv
// Host model: APB master and demand source.
// Assumes the slave answers within sixteen cycles.
`timescale 1ns/10ps
`default_nettype none
module bfr_host_model (
  // Clock and bus answer
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Bus request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [bfr_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // Operating demand
  output logic [bfr_pkg::DEMAND_W-1:0] demand
);
  logic timed_out = 1'b0;
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    demand = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int c;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pready !== 1'b1 && c < 16);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) timed_out = 1'b1;
    {psel, penable} <= 2'h0;
    // Released bus shows inverted values
    {pwrite, paddr, pwdata} <= ~{w, a, d};
  endtask : xfer
  task automatic redemand(input logic [7:0] v);
    @(posedge clk) demand <= '0;
    repeat (2) @(posedge clk);
    demand <= v;
  endtask : redemand
  task automatic rerun(input logic [31:0] c);
    logic [31:0] q;
    logic e;
    xfer(1'b1, bfr_pkg::OFS_CTRL, c & ~32'h1, q, e);
    xfer(1'b1, bfr_pkg::OFS_CTRL, c | 32'h1, q, e);
  endtask : rerun
endmodule : bfr_host_model
`default_nettype wire

// ### dv/bfr_top_test.sv
// Self-checking bench for bfr_top.
// Assumes a short host reset hold for a quick run.
`timescale 1ns/10ps
`default_nettype none
module bfr_top_test;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] fl = 6'h00;
  logic [5:0] boot = 6'h0, drain_source_voltage = 6'h0, req = 6'h0, gate, b;
  logic [31:0] prdata, pwdata, q;
  logic [7:0] paddr, demand;
  logic psel, penable, pwrite, pready, pslverr, restart, hrst_n, irq, e;
  int n_errors = 0;
  int checks = 0;
  int n;
  always #5 clk = ~clk;
  bfr_host_model host (.clk(clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .demand(demand));
  bfr_top #(.HOLD_CYCLES(HOLD)) dut (.SYS_CLK(clk), .RESET_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FLT_MAIN_UV(fl[0]), .FLT_LOGIC_UV(fl[1]), .FLT_GDREG_UV(fl[5]),
    .FLT_BOOT_UV(boot), .FLT_VDS_OV(drain_source_voltage), .FLT_TEMP_WARN(fl[2]),
    .FLT_OVERTEMP(fl[3]), .FLT_SYNC_LOSS(fl[4]), .GATE_REQ(req),
    .DEMAND(demand), .GATE_OUT(gate), .MOTOR_RESTART(restart),
    .HOST_RESET_OUT_N(hrst_n), .IRQ(irq));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    host.xfer(1'b0, a, 32'h0, q, e);
    check(q & m, x);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clk) fl[i] <= 1'b1;
    @(posedge clk) fl[i] <= 1'b0;
  endtask : pulse
  function automatic logic [31:0] egate(input logic [5:0] r, k);
    return {26'h0, r & ~k};
  endfunction : egate
  task automatic give_verdict;
    if (host.timed_out === 1'b1) n_errors++;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #900000;
    n_errors++;
    give_verdict;
  end
  initial begin
    n = $urandom(53195);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(HOLD - 2);
    check(32'(hrst_n), 32'h0);
    tick(4);
    check(32'(hrst_n), 32'h1);
    rd(bfr_pkg::OFS_CTRL, 32'hF, 32'h0);
    rd(bfr_pkg::OFS_IRQ_MASK, 32'hFF, 32'h0);
    wr(bfr_pkg::OFS_CTRL, 32'h1);
    host.redemand(8'h5A);
    repeat (6) begin
      @(posedge clk) req <= 6'($urandom);
      tick(2);
      check(32'(gate), egate(req, 6'h0));
    end
    for (int k = 0; k < 2; k++) begin
      b = 6'h1 << ($urandom % 6);
      @(posedge clk) req <= 6'h3F;
      {drain_source_voltage, boot} <= k ? {b, 6'h0} : {6'h0, b};
      tick(2);
      check(32'(gate), egate(6'h3F, b));
      @(posedge clk) {drain_source_voltage, boot} <= 12'h0;
      tick(2);
      check(32'(gate), egate(6'h3F, b));
      @(posedge clk) req <= ~b;
      @(posedge clk) req <= 6'h3F;
      tick(2);
      check(32'(gate), 32'h3F);
    end
    pulse(0);
    tick(2);
    check(32'(gate), 32'h3F);
    wr(bfr_pkg::OFS_CTRL, 32'h9);
    repeat (2) rd(bfr_pkg::OFS_STATUS, 32'h100, 32'h100);
    wr(bfr_pkg::OFS_CTRL, 32'h1);
    rd(bfr_pkg::OFS_DIAG, 32'h3F3F, 32'h0);
    rd(bfr_pkg::OFS_STATUS, 32'h100, 32'h0);
    pulse(0);
    host.redemand(8'h5A);
    rd(bfr_pkg::OFS_STATUS, 32'h100, 32'h0);
    pulse(4);
    tick(2);
    check(32'(gate), 32'h0);
    rd(bfr_pkg::OFS_STATUS, 32'h200, 32'h200);
    rd(bfr_pkg::OFS_STATUS, 32'h200, 32'h0);
    check(32'(gate), 32'h0);
    host.redemand(8'h21);
    tick(2);
    check(32'(gate), 32'h3F);
    pulse(4);
    tick(2);
    check(32'(gate), 32'h0);
    host.rerun(32'h1);
    tick(2);
    check(32'(gate), 32'h3F);
    wr(bfr_pkg::OFS_CTRL, 32'h5);
    pulse(4);
    tick(0);
    check(32'(gate), 32'h0);
    n = 0;
    while (restart !== 1'b1 && n < 9) begin
      tick(1);
      n++;
    end
    check(32'(restart), 32'h1);
    tick(2);
    check(32'(gate), 32'h3F);
    wr(bfr_pkg::OFS_CTRL, 32'h1);
    for (int i = 2; i < 4; i++) begin
      @(posedge clk) fl[i] <= 1'b1;
      tick(2);
      check(32'(gate), 32'h3F);
      rd(bfr_pkg::OFS_STATUS, 32'h60, 32'h1 << (i + 3));
      @(posedge clk) fl[i] <= 1'b0;
      rd(bfr_pkg::OFS_STATUS, 32'h60, 32'h0);
    end
    @(posedge clk) fl[1] <= 1'b1;
    tick(2);
    check(32'(gate), 32'h0);
    check(32'(hrst_n), 32'h0);
    @(posedge clk) fl[1] <= 1'b0;
    n = 0;
    while (hrst_n !== 1'b1 && n < 99) begin
      tick(1);
      n++;
    end
    check(32'(n >= HOLD && n <= HOLD + 2), 32'h1);
    host.rerun(32'h1);
    tick(2);
    check(32'(gate), 32'h3F);
    @(posedge clk) fl[5] <= 1'b1;
    tick(2);
    check(32'(gate), 32'h0);
    @(posedge clk) fl[5] <= 1'b0;
    tick(2);
    check(32'(gate), 32'h3F);
    wr(bfr_pkg::OFS_IRQ_STAT, 32'hFF);
    pulse(0);
    tick(2);
    check(32'(irq), 32'h0);
    rd(bfr_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    wr(bfr_pkg::OFS_IRQ_MASK, 32'h1);
    tick(2);
    check(32'(irq), 32'h1);
    wr(bfr_pkg::OFS_IRQ_STAT, 32'h1);
    tick(2);
    check(32'(irq), 32'h0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    check(32'(e), 32'h1);
    give_verdict;
  end
endmodule : bfr_top_test
`default_nettype wire
